//--- hdl/ssrp_port.sv
// Function
// (R1) Host I2C write: address with write bit, then address/data pairs, then stop.
// (R2) Host sends start register in a write, then stop or repeated start, before reading.
// (R3) I2C read returns consecutive registers until master not-acknowledge and stop.
// (R4) I2C address LSB follows the current address-select pin level.
// (R5) SPI mode 00 or 11 detected from clock level after select falls.
// (R6) Three-wire select makes serial-in a bidirectional data line.
// (R7) Serial-out pin stays high impedance in three-wire operation.
// (R8) Chip select is active low; undriven means inactive.
// (R9) SPI samples on rising clock, changes output on falling clock.
// (R10) Host frames SPI with select low/high, clock steady at select edges.
// (R11) SPI control byte: bit 7 direction, low seven bits address, MSB implied.
// (R12) Register F7h written with control 77h, read with F7h.
// (R13) SPI write is control/data pairs in one select, no auto increment.
// (R14) Host ends SPI write by raising select after last data byte.
// (R15) SPI read streams data while select low, address incrementing per byte.
// (R16) Read data leaves on serial-out in four-wire, serial-in in three-wire.
// (R17) First select low disables I2C until the next power-on reset.
// (R18) I2C never stretches the clock; clock is input only.
// (R19) Three-wire select lives in bit 0 of configuration register F5h.
// (R20) SPI bytes travel MSB first; direction flag is the first bit.
// (R21) I2C acknowledges own address and received bytes, ignores other targets; here a data byte that meets a full FIFO gets a not-acknowledge.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module ssrp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,       // System clock
  input  wire logic             reset,     // Synchronous reset
  input  wire logic             in_valid,  // Push request
  output logic                  in_ready,  // Room for a word
  input  wire logic [WIDTH-1:0] in_data,   // Word pushed
  output logic                  out_valid, // Word available
  input  wire logic             out_ready, // Consumer takes word
  output logic      [WIDTH-1:0] out_data   // Head word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;

  // Extra pointer bit tells full from empty
  assign in_ready  = (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]) || (wr_ptr[AW] == rd_ptr[AW]);
  assign out_valid = wr_ptr != rd_ptr;
  assign out_data  = mem[rd_ptr[AW-1:0]];

  // Storage write
  always_ff @(posedge clk)
  begin
    if (in_valid && in_ready)
    begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  // Pointer update
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      if (in_valid && in_ready)
        wr_ptr <= wr_ptr + 1'b1;
      if (out_valid && out_ready)
        rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule : ssrp_fifo

////////////////////////////////////////////////////////////////////////////////
module ssrp_port (
  input  wire logic       clk,               // System clock, 10 MHz
  input  wire logic       reset,             // Synchronous power-on reset
  input  wire logic       sck,               // Serial clock pin
  input  wire logic       csb_n,             // Chip select pin, active low
  input  wire logic       sdi_in,            // Serial-in / SDA pin level
  output logic            sdi_out,           // Serial-in pin drive value
  output logic            sdi_oe,            // Serial-in pin drive enable
  input  wire logic       sdo_in,            // Serial-out / address-select level
  output logic            sdo_out,           // Serial-out pin drive value
  output logic            sdo_oe,            // Serial-out pin drive enable
  output logic            wr_valid,          // Register write available
  input  wire logic       wr_ready,          // Register file takes write
  output logic      [7:0] wr_addr,           // Register write address
  output logic      [7:0] wr_data,           // Register write data
  output logic      [7:0] rd_addr,           // Register read address
  input  wire logic [7:0] rd_data,           // Register read data, same cycle
  output logic            three_wire_select, // Three-wire SPI enabled
  output logic            spi_mode11,        // Last SPI frame began with clock high
  output logic            i2c_disabled,      // I2C front end locked out
  output logic            wr_dropped         // SPI write lost to a full FIFO
);
  logic [3:0] pin_raw;
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic [3:0] sync3;
  logic       sck_l;
  logic       sck_rise;
  logic       sck_fall;
  logic       csb_fall;
  logic       csb_rise;
  logic       sda_l;
  logic       sda_rise;
  logic       sda_fall;
  logic       asel_l;
  logic [7:0] spi_byte;
  logic [7:0] i2c_byte;

  ssrp_pkg::ssrp_spi_state_type spi_state;
  logic [2:0] spi_cnt;
  logic [7:0] spi_sh;
  logic [7:0] spi_addr;
  logic [7:0] spi_wbyte;
  logic       spi_push;
  logic       spi_rd_set;
  logic       spi_rd_next;
  logic       spi_shift;
  logic       spi_bit;

  ssrp_pkg::ssrp_i2c_state_type i2c_state;
  logic [2:0] i2c_cnt;
  logic [7:0] i2c_sh;
  logic [7:0] i2c_ptr;
  logic [7:0] i2c_wbyte;
  logic       i2c_pair;
  logic       i2c_read;
  logic       i2c_ack_ok;
  logic       i2c_ack_on;
  logic       i2c_oe;
  logic       i2c_push;
  logic       i2c_rd_set;
  logic       i2c_rd_next;
  logic       i2c_shift;

  logic       load_pend;
  logic [7:0] tx;
  logic       push_any;
  logic [7:0] push_addr;
  logic [7:0] push_data;
  logic       fifo_in_ready;
  logic [ssrp_pkg::FIFO_WIDTH-1:0] fifo_out;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; third stage only feeds edge detection
  assign pin_raw = {sdo_in, sdi_in, csb_n, sck};

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      sync1 <= ssrp_pkg::SYNC_RESET;
      sync2 <= ssrp_pkg::SYNC_RESET;
      sync3 <= ssrp_pkg::SYNC_RESET;
    end
    else
    begin
      sync1 <= pin_raw;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // Edge terms from the settled stages
  assign sck_l    = sync2[ssrp_pkg::PIN_SCK];
  assign sck_rise = sck_l & ~sync3[ssrp_pkg::PIN_SCK];
  assign sck_fall = ~sck_l & sync3[ssrp_pkg::PIN_SCK];
  // (R8) select low is active
  assign csb_fall = ~sync2[ssrp_pkg::PIN_CSB] & sync3[ssrp_pkg::PIN_CSB];
  assign csb_rise = sync2[ssrp_pkg::PIN_CSB] & ~sync3[ssrp_pkg::PIN_CSB];
  assign sda_l    = sync2[ssrp_pkg::PIN_SDI];
  assign sda_rise = sda_l & ~sync3[ssrp_pkg::PIN_SDI];
  assign sda_fall = ~sda_l & sync3[ssrp_pkg::PIN_SDI];
  assign asel_l   = sync2[ssrp_pkg::PIN_SDO];
  // (R20) bytes assemble MSB first
  assign spi_byte = {spi_sh[6:0], sda_l};
  assign i2c_byte = {i2c_sh[6:0], sda_l};

  ////////////////////////////////////////////////////////////////////////////
  // Interface lock: only a power-on reset brings I2C back
  always_ff @(posedge clk)
  begin
    if (reset)
      i2c_disabled <= 1'b0;
    // (R17) lock on select low
    else if (csb_fall)
      i2c_disabled <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // SPI front end; clock edges count only while select is low
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      spi_state   <= ssrp_pkg::SPI_IDLE;
      spi_cnt     <= '0;
      spi_sh      <= ssrp_pkg::BYTE_RESET;
      spi_addr    <= ssrp_pkg::BYTE_RESET;
      spi_wbyte   <= ssrp_pkg::BYTE_RESET;
      spi_push    <= 1'b0;
      spi_rd_set  <= 1'b0;
      spi_rd_next <= 1'b0;
      spi_shift   <= 1'b0;
      spi_bit     <= 1'b1;
      spi_mode11  <= 1'b0;
    end
    else
    begin
      spi_push    <= 1'b0;
      spi_rd_set  <= 1'b0;
      spi_rd_next <= 1'b0;
      spi_shift   <= 1'b0;
      if (csb_fall)
      begin
        spi_state  <= ssrp_pkg::SPI_CTRL;
        spi_cnt    <= '0;
        // (R5) clock level after select falls
        spi_mode11 <= sck_l;
      end
      else if (csb_rise)
        spi_state <= ssrp_pkg::SPI_IDLE;
      else if (spi_state != ssrp_pkg::SPI_IDLE)
      begin
        // (R9) sample on rising edge
        if (sck_rise)
        begin
          spi_sh  <= spi_byte;
          spi_cnt <= spi_cnt + 1'b1;
          if (spi_cnt == ssrp_pkg::LAST_BIT)
          begin
            case (spi_state)
              ssrp_pkg::SPI_CTRL:
              begin
                // (R11) direction flag and implied MSB
                // (R12) control 77h/F7h map to F7h
                spi_addr <= ssrp_pkg::ADDR_MSB | {1'b0, spi_byte[6:0]};
                spi_rd_set <= spi_byte[7];
                spi_state  <= spi_byte[7] ? ssrp_pkg::SPI_RDATA : ssrp_pkg::SPI_WDATA;
              end
              ssrp_pkg::SPI_WDATA:
              begin
                // (R13) each pair stands alone
                spi_wbyte <= spi_byte;
                spi_push  <= 1'b1;
                spi_state <= ssrp_pkg::SPI_CTRL;
              end
              ssrp_pkg::SPI_RDATA:
                // (R15) next address per byte
                spi_rd_next <= 1'b1;
              default:
                spi_state <= ssrp_pkg::SPI_IDLE;
            endcase
          end
        end
        // (R9) change output on falling edge
        if (sck_fall && spi_state == ssrp_pkg::SPI_RDATA)
        begin
          spi_bit   <= tx[7];
          spi_shift <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // I2C front end; SDA is only pulled low
  // (R18) clock never held
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      i2c_state   <= ssrp_pkg::I2C_IDLE;
      i2c_cnt     <= '0;
      i2c_sh      <= ssrp_pkg::BYTE_RESET;
      i2c_ptr     <= ssrp_pkg::BYTE_RESET;
      i2c_wbyte   <= ssrp_pkg::BYTE_RESET;
      i2c_pair    <= 1'b0;
      i2c_read    <= 1'b0;
      i2c_ack_ok  <= 1'b0;
      i2c_ack_on  <= 1'b0;
      i2c_oe      <= 1'b0;
      i2c_push    <= 1'b0;
      i2c_rd_set  <= 1'b0;
      i2c_rd_next <= 1'b0;
      i2c_shift   <= 1'b0;
    end
    else
    begin
      i2c_push    <= 1'b0;
      i2c_rd_set  <= 1'b0;
      i2c_rd_next <= 1'b0;
      i2c_shift   <= 1'b0;
      // (R17) locked front end stays silent
      if (i2c_disabled || csb_fall)
      begin
        i2c_state <= ssrp_pkg::I2C_IDLE;
        i2c_oe    <= 1'b0;
      end
      else if (sck_l && sda_fall)
      begin
        // (R2) start or repeated start
        i2c_state  <= ssrp_pkg::I2C_ADDR;
        i2c_cnt    <= '0;
        i2c_pair   <= 1'b0;
        i2c_ack_on <= 1'b0;
        i2c_oe     <= 1'b0;
      end
      else if (sck_l && sda_rise)
      begin
        i2c_state <= ssrp_pkg::I2C_IDLE;
        i2c_oe    <= 1'b0;
      end
      else
      begin
        case (i2c_state)
          ssrp_pkg::I2C_ADDR:
            if (sck_rise)
            begin
              i2c_sh  <= i2c_byte;
              i2c_cnt <= i2c_cnt + 1'b1;
              if (i2c_cnt == ssrp_pkg::LAST_BIT)
              begin
                // (R4) live address-select level
                // (R21) other targets ignored
                if (i2c_sh[6:0] == {ssrp_pkg::I2C_ADDR_HI, asel_l})
                begin
                  i2c_state  <= ssrp_pkg::I2C_AACK;
                  i2c_ack_ok <= 1'b1;
                  i2c_read   <= sda_l;
                  i2c_rd_set <= sda_l;
                end
                else
                  i2c_state <= ssrp_pkg::I2C_IDLE;
              end
            end
          ssrp_pkg::I2C_AACK, ssrp_pkg::I2C_RACK:
            if (sck_fall)
            begin
              // (R21) acknowledge slot
              i2c_ack_on <= ~i2c_ack_on;
              i2c_cnt    <= '0;
              if (!i2c_ack_on)
                i2c_oe <= i2c_ack_ok;
              else if (i2c_state == ssrp_pkg::I2C_AACK && i2c_read)
              begin
                i2c_state <= ssrp_pkg::I2C_TXB;
                i2c_oe    <= ~tx[7];
                i2c_shift <= 1'b1;
              end
              else
              begin
                i2c_oe    <= 1'b0;
                i2c_state <= i2c_ack_ok ? ssrp_pkg::I2C_RXB : ssrp_pkg::I2C_IDLE;
              end
            end
          ssrp_pkg::I2C_RXB:
            if (sck_rise)
            begin
              i2c_sh  <= i2c_byte;
              i2c_cnt <= i2c_cnt + 1'b1;
              if (i2c_cnt == ssrp_pkg::LAST_BIT)
              begin
                i2c_state <= ssrp_pkg::I2C_RACK;
                i2c_pair  <= ~i2c_pair;
                // (R1) address byte, then its data byte
                if (!i2c_pair)
                begin
                  i2c_ptr    <= i2c_byte;
                  i2c_ack_ok <= 1'b1;
                end
                else
                begin
                  // Full FIFO answers with a not-acknowledge
                  i2c_wbyte  <= i2c_byte;
                  i2c_ack_ok <= fifo_in_ready;
                  i2c_push   <= fifo_in_ready;
                end
              end
            end
          ssrp_pkg::I2C_TXB:
          begin
            if (sck_fall)
            begin
              i2c_oe    <= ~tx[7];
              i2c_shift <= 1'b1;
            end
            if (sck_rise)
            begin
              i2c_cnt <= i2c_cnt + 1'b1;
              if (i2c_cnt == ssrp_pkg::LAST_BIT)
                i2c_state <= ssrp_pkg::I2C_MACK;
            end
          end
          ssrp_pkg::I2C_MACK:
          begin
            if (sck_fall)
              i2c_oe <= 1'b0;
            // (R3) continue on acknowledge, stop on not-acknowledge
            if (sck_rise)
            begin
              i2c_cnt     <= '0;
              i2c_rd_next <= ~sda_l;
              i2c_state   <= sda_l ? ssrp_pkg::I2C_IDLE : ssrp_pkg::I2C_TXB;
            end
          end
          default:
            i2c_state <= ssrp_pkg::I2C_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read pointer and transmit byte; data is fetched one cycle after the address
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rd_addr   <= ssrp_pkg::BYTE_RESET;
      load_pend <= 1'b0;
      tx        <= ssrp_pkg::BYTE_RESET;
    end
    else
    begin
      load_pend <= spi_rd_set | i2c_rd_set | spi_rd_next | i2c_rd_next;
      if (spi_rd_set)
        rd_addr <= spi_addr;
      else if (i2c_rd_set)
        rd_addr <= i2c_ptr;
      // (R15) auto increment
      else if (spi_rd_next || i2c_rd_next)
        rd_addr <= rd_addr + 1'b1;
      if (load_pend)
        tx <= rd_data;
      else if (spi_shift || i2c_shift)
        tx <= {tx[6:0], 1'b0};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write path into the FIFO; only one front end is ever active
  assign push_any  = spi_push | i2c_push;
  assign push_addr = i2c_disabled ? spi_addr : i2c_ptr;
  assign push_data = i2c_disabled ? spi_wbyte : i2c_wbyte;

  // Configuration bit and overflow report
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      three_wire_select <= ssrp_pkg::CFG_3W_RESET;
      wr_dropped        <= 1'b0;
    end
    else
    begin
      wr_dropped <= spi_push & ~fifo_in_ready;
      // (R19) bit 0 of F5h
      if (push_any && fifo_in_ready && push_addr == ssrp_pkg::CFG_ADDR)
        three_wire_select <= push_data[ssrp_pkg::CFG_3W_BIT];
    end
  end

  ssrp_fifo #(
    .WIDTH (ssrp_pkg::FIFO_WIDTH),
    .DEPTH (ssrp_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .reset     (reset),
    .in_valid  (push_any),
    .in_ready  (fifo_in_ready),
    .in_data   ({push_addr, push_data}),
    .out_valid (wr_valid),
    .out_ready (wr_ready),
    .out_data  (fifo_out)
  );

  assign wr_addr = fifo_out[15:8];
  assign wr_data = fifo_out[7:0];

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers
  // (R16) read data pin follows wiring mode
  // (R7) serial-out released in three-wire
  assign sdo_out = spi_bit;
  assign sdo_oe  = (spi_state == ssrp_pkg::SPI_RDATA) & ~three_wire_select;
  // (R6) serial-in turns around in three-wire
  assign sdi_out = i2c_disabled ? spi_bit : 1'b0;
  assign sdi_oe  = i2c_disabled ? ((spi_state == ssrp_pkg::SPI_RDATA) & three_wire_select) : i2c_oe;
endmodule : ssrp_port
`default_nettype wire

//--- shared/ssrp_pkg.sv
`default_nettype none
package ssrp_pkg;
  // Fixed upper six bits of the I2C target address
  localparam logic [5:0] I2C_ADDR_HI = 6'h3B;
  // Configuration register and its three-wire bit
  localparam logic [7:0] CFG_ADDR     = 8'hF5;
  localparam int         CFG_3W_BIT   = 0;
  localparam logic       CFG_3W_RESET = 1'b0;
  // Implied register address MSB in SPI control bytes
  localparam logic [7:0] ADDR_MSB     = 8'h80;
  localparam logic [2:0] LAST_BIT     = 3'h7;
  // Write path FIFO: register address and data per word
  localparam int         FIFO_WIDTH   = 16;
  localparam int         FIFO_DEPTH   = 8;
  // Pin positions in the synchroniser vector; reset matches the idle-high pins
  localparam int         PIN_SCK      = 0;
  localparam int         PIN_CSB      = 1;
  localparam int         PIN_SDI      = 2;
  localparam int         PIN_SDO      = 3;
  localparam logic [3:0] SYNC_RESET   = 4'h7;
  localparam logic [7:0] BYTE_RESET   = 8'h00;
  typedef enum logic [1:0] {SPI_IDLE, SPI_CTRL, SPI_WDATA, SPI_RDATA} ssrp_spi_state_type;
  typedef enum logic [2:0] {I2C_IDLE, I2C_ADDR, I2C_AACK, I2C_RXB, I2C_RACK, I2C_TXB, I2C_MACK} ssrp_i2c_state_type;
endpackage : ssrp_pkg
`default_nettype wire

//--- verification/ssrp_host.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module ssrp_host (
  input  wire logic clk,   // Bench clock
  input  wire logic sdi_w, // Resolved serial-in wire
  input  wire logic sdo_w, // Resolved serial-out wire
  output logic      sck,   // Serial clock pin
  output logic      csb_n, // Chip select pin
  output logic      h_oe,  // Host drives serial-in wire
  output logic      h_val  // Host drive value
);
  // Idle: clock high, deselected, released
  initial
  begin
    sck = 1'b1;
    csb_n = 1'b1;
    h_oe = 1'b0;
    h_val = 1'b1;
  end
  task wait_clk(input int n);
    repeat (n) @(negedge clk);
  endtask : wait_clk
  task spi_begin(input logic m11);
    sck = m11;
    wait_clk(4);
    csb_n = 1'b0;
    wait_clk(4);
  endtask : spi_begin
  task spi_end(input logic m11);
    sck = m11;
    wait_clk(4);
    csb_n = 1'b1;
    h_oe = 1'b0;
    wait_clk(4);
  endtask : spi_end
  task spi_byte(input logic [7:0] tx, input logic drv, input logic three_w, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      sck = 1'b0;
      h_oe = drv;
      h_val = tx[i];
      wait_clk(4);
      sck = 1'b1;
      wait_clk(4);
      rx[i] = three_w ? sdi_w : sdo_w; // Held till next fall
    end
  endtask : spi_byte
  // Start: data falls, clock high
  task i2c_start();
    h_oe = 1'b0;
    wait_clk(4);
    sck = 1'b1;
    wait_clk(4);
    h_oe = 1'b1;
    h_val = 1'b0;
    wait_clk(4);
    sck = 1'b0;
    wait_clk(4);
  endtask : i2c_start
  task i2c_stop();
    wait_clk(1);
    h_oe = 1'b1;
    h_val = 1'b0;
    wait_clk(3);
    sck = 1'b1;
    wait_clk(4);
    h_oe = 1'b0;
    wait_clk(4);
  endtask : i2c_stop
  // Nine bits; a one releases the wire
  task i2c_byte(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--)
    begin
      sck = 1'b0;
      wait_clk(1);
      h_oe = !tx[i];
      h_val = 1'b0;
      wait_clk(3);
      sck = 1'b1;
      wait_clk(4);
      rx[i] = sdi_w;
    end
    sck = 1'b0;
  endtask : i2c_byte
endmodule : ssrp_host
`default_nettype wire

//--- verification/ssrp_port_bench.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module ssrp_port_bench;
  logic       clk = 1'b0;
  logic       reset = 1'b1;
  logic       addr_sel = 1'b0;
  logic       wr_ready = 1'b0;
  wire        sdi_out, sdi_oe, sdo_out, sdo_oe, wr_valid, three_wire_select, spi_mode11, i2c_disabled, wr_dropped;
  wire  [7:0] wr_addr, wr_data, rd_addr, rd_data;
  wire        sck, csb_n, h_oe, h_val, sdi_w, sdo_w;
  int         errors = 0;
  int         check_count = 0;
  int         drops = 0;
  always #50 clk = ~clk;
  // Register file stand-in
  assign rd_data = rd_addr ^ 8'h3C;
  // Host wins a clash; released wire pulls up
  assign sdi_w = h_oe ? h_val : (sdi_oe ? sdi_out : 1'b1);
  assign sdo_w = sdo_oe ? sdo_out : addr_sel;
  always @(posedge clk) if (wr_dropped === 1'b1) drops++;
  ssrp_host u_host (.clk, .sdi_w, .sdo_w, .sck, .csb_n, .h_oe, .h_val);
  ssrp_port u_dut (.clk, .reset, .sck, .csb_n, .sdi_in(sdi_w), .sdi_out, .sdi_oe, .sdo_in(sdo_w), .sdo_out,
    .sdo_oe, .wr_valid, .wr_ready, .wr_addr, .wr_data, .rd_addr, .rd_data, .three_wire_select, .spi_mode11,
    .i2c_disabled, .wr_dropped);
  task check(input logic [15:0] got, input logic [15:0] exp, input string what);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check
  task close_out();
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  // Pop one write word
  task pop(input logic [15:0] exp);
    for (int n = 0; n < 50 && wr_valid !== 1'b1; n++) u_host.wait_clk(1);
    check({wr_addr, wr_data}, exp, "write word");
    wr_ready = 1'b1;
    u_host.wait_clk(1);
    wr_ready = 1'b0;
    u_host.wait_clk(1);
  endtask : pop
  task test_reset();
    check({sdo_oe, sdi_oe, wr_valid, three_wire_select, i2c_disabled, sdo_out}, 16'h0001, "reset state");
  endtask : test_reset
  task test_i2c();
    logic [8:0] r;
    u_host.i2c_start();
    u_host.i2c_byte({8'hEE, 1'b1}, r);
    check(r[0], 16'h0001, "other address ack");
    u_host.i2c_stop();
    u_host.i2c_start();
    u_host.i2c_byte({8'hEC, 1'b1}, r);
    check(r[0], 16'h0000, "own address ack");
    u_host.i2c_byte({8'hF4, 1'b1}, r);
    check(r[0], 16'h0000, "register ack");
    u_host.i2c_byte({8'h5A, 1'b1}, r);
    check(r[0], 16'h0000, "data ack");
    u_host.i2c_stop();
    pop(16'hF45A);
    addr_sel = 1'b1;
    u_host.i2c_start();
    u_host.i2c_byte({8'hEE, 1'b1}, r);
    check(r[0], 16'h0000, "address select ack");
    u_host.i2c_byte({8'hF7, 1'b1}, r);
    u_host.i2c_start();
    u_host.i2c_byte({8'hEF, 1'b1}, r);
    u_host.i2c_byte({8'hFF, 1'b0}, r);
    check(r[8:1], 16'h00CB, "first read byte");
    u_host.i2c_byte({8'hFF, 1'b1}, r);
    check(r[8:1], 16'h00C4, "next read byte");
    u_host.i2c_stop();
    check(i2c_disabled, 16'h0000, "lock before select");
  endtask : test_i2c
  task test_read4();
    logic [7:0] r;
    u_host.spi_begin(1'b0);
    u_host.spi_byte(8'hF7, 1'b1, 1'b0, r);
    u_host.spi_byte(8'h00, 1'b1, 1'b0, r);
    check(r, 16'h00CB, "spi read F7");
    u_host.spi_byte(8'h00, 1'b1, 1'b0, r);
    check(r, 16'h00C4, "spi read F8");
    u_host.spi_end(1'b0);
    check({spi_mode11, i2c_disabled, three_wire_select}, 16'h0002, "mode 00 flags");
  endtask : test_read4
  task test_write_fill();
    logic [7:0] r;
    u_host.spi_begin(1'b1);
    u_host.spi_byte(8'h75, 1'b1, 1'b0, r);
    u_host.spi_byte(8'h01, 1'b1, 1'b0, r);
    for (int k = 0; k < 8; k++)
    begin
      u_host.spi_byte(8'h10 + 8'(k), 1'b1, 1'b0, r);
      u_host.spi_byte(8'(k), 1'b1, 1'b0, r);
    end
    u_host.spi_end(1'b1);
    check(drops, 16'h0001, "dropped writes");
    check({spi_mode11, three_wire_select}, 16'h0003, "mode 11, 3-wire");
    pop(16'hF501);
    for (int k = 0; k < 7; k++) pop({8'h90 + 8'(k), 8'(k)});
    check(wr_valid, 16'h0000, "buffer empty");
  endtask : test_write_fill
  task test_read3();
    logic [7:0] r;
    u_host.spi_begin(1'b1);
    u_host.spi_byte(8'hF7, 1'b1, 1'b1, r);
    u_host.spi_byte(8'h00, 1'b0, 1'b1, r);
    check(r, 16'h00CB, "3-wire read F7");
    u_host.spi_byte(8'h00, 1'b0, 1'b1, r);
    check(r, 16'h00C4, "3-wire read F8");
    u_host.spi_end(1'b1);
  endtask : test_read3
  // I2C first: a select fall locks it out
  initial
  begin
    u_host.wait_clk(12);
    reset = 1'b0;
    u_host.wait_clk(4);
    test_reset();
    test_i2c();
    test_read4();
    test_write_fill();
    test_read3();
    close_out();
  end
  // Watchdog, far beyond the run
  initial
  begin
    repeat (30000) @(posedge clk);
    errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    close_out();
  end
endmodule : ssrp_port_bench
bind ssrp_port ssrp_port_props u_props (.clk, .reset, .sck, .csb_n, .sdi_oe, .sdo_out, .sdo_oe, .wr_valid,
  .wr_ready, .wr_addr, .wr_data, .three_wire_select, .i2c_disabled, .wr_dropped);
`default_nettype wire

//--- verification/ssrp_port_props.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module ssrp_port_props (
  input wire logic       clk,               // System clock
  input wire logic       reset,             // Synchronous reset
  input wire logic       sck,               // Serial clock pin
  input wire logic       csb_n,             // Chip select pin
  input wire logic       sdi_oe,            // Serial-in drive enable
  input wire logic       sdo_out,           // Serial-out drive value
  input wire logic       sdo_oe,            // Serial-out drive enable
  input wire logic       wr_valid,          // Write available
  input wire logic       wr_ready,          // Write taken
  input wire logic [7:0] wr_addr,           // Write address
  input wire logic [7:0] wr_data,           // Write data
  input wire logic       three_wire_select, // Three-wire mode
  input wire logic       i2c_disabled,      // I2C locked out
  input wire logic       wr_dropped         // Write lost
);
  // One clock domain
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  property p_reset_quiet;
    $fell(reset) |-> !sdo_oe && !sdi_oe && !wr_valid && !i2c_disabled;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy after reset");
  // Two sync flops plus edge detect
  property p_lock_set;
    $fell(csb_n) |-> ##[1:5] i2c_disabled;
  endproperty
  a_lock_set: assert property (p_lock_set) else $error("I2C not locked");
  property p_lock_keep;
    i2c_disabled |=> i2c_disabled;
  endproperty
  a_lock_keep: assert property (p_lock_keep) else $error("I2C lock released");
  property p_3w_sdo;
    three_wire_select |-> !sdo_oe;
  endproperty
  a_3w_sdo: assert property (p_3w_sdo) else $error("serial-out driven in three-wire");
  property p_one_driver;
    !(sdi_oe && sdo_oe);
  endproperty
  a_one_driver: assert property (p_one_driver) else $error("both data pins driven");
  property p_spi_sdi;
    i2c_disabled && sdi_oe |-> three_wire_select;
  endproperty
  a_spi_sdi: assert property (p_spi_sdi) else $error("serial-in driven in four-wire");
  property p_release;
    $rose(csb_n) |-> ##[1:5] (!sdo_oe && !sdi_oe);
  endproperty
  a_release: assert property (p_release) else $error("pins driven after deselect");
  // Serial-out bits change only while the clock is low
  property p_sdo_edge;
    !csb_n && sdo_oe && $past(sdo_oe) && $changed(sdo_out) |-> !sck;
  endproperty
  a_sdo_edge: assert property (p_sdo_edge) else $error("bit changed, clock high");
  property p_wr_hold;
    wr_valid && !wr_ready |=> wr_valid && $stable({wr_addr, wr_data});
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("stalled write word changed");
  property p_drop_pulse;
    wr_dropped |-> wr_valid ##1 !wr_dropped;
  endproperty
  a_drop_pulse: assert property (p_drop_pulse) else $error("bad drop pulse");
  c_drop: cover property ($rose(wr_dropped));
  c_3w: cover property ($rose(three_wire_select));
  c_3w_read: cover property ($rose(sdi_oe) && i2c_disabled);
endmodule : ssrp_port_props
`default_nettype wire
